/* pirq_pkg.sv */
// constants, types and register map of the peripheral interrupt flag bank
package pirq_pkg;

  // ----------------------------------------------------------------
  // bus and register map
  // ----------------------------------------------------------------
  localparam int unsigned PIRQ_ADDR_W = 8;
  localparam int unsigned PIRQ_DATA_W = 32;
  localparam int unsigned PIRQ_REG_W = 8;

  localparam logic [7:0] PIRQ_OFF_FLAGS_ONE = 8'h00;
  localparam logic [7:0] PIRQ_OFF_FLAGS_TWO = 8'h04;
  localparam logic [7:0] PIRQ_OFF_FLAGS_THREE = 8'h08;
  localparam logic [7:0] PIRQ_OFF_ENABLES_ONE = 8'h0C;
  localparam logic [7:0] PIRQ_OFF_ENABLES_TWO = 8'h10;
  localparam logic [7:0] PIRQ_OFF_ENABLES_THREE = 8'h14;
  localparam logic [7:0] PIRQ_OFF_PRIORITY_ONE = 8'h18;
  localparam logic [7:0] PIRQ_OFF_CONTROL = 8'h1C;
  localparam logic [7:0] PIRQ_OFF_IRQ_STATUS = 8'h20;
  localparam logic [7:0] PIRQ_OFF_IRQ_MASK = 8'h24;

  localparam logic [1:0] PIRQ_RESP_OKAY = 2'h0;
  localparam logic [1:0] PIRQ_RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // field layouts and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PIRQ_MASK_ONE = 8'hFF;
  localparam logic [7:0] PIRQ_MASK_TWO = 8'hC9;
  localparam logic [7:0] PIRQ_MASK_THREE = 8'hC0;
  localparam logic [7:0] PIRQ_MASK_NO_PSP = 8'h7F;
  localparam logic [7:0] PIRQ_RST_ZERO = 8'h00;
  localparam logic [7:0] PIRQ_RST_PRIORITY = 8'hFF;

  localparam int unsigned PIRQ_BIT_OSC_FAIL = 7;
  localparam int unsigned PIRQ_BIT_CMP_CHANGE = 6;
  localparam int unsigned PIRQ_BIT_BUS_COLL_ONE = 3;
  localparam int unsigned PIRQ_BIT_CAPCOMP_TWO = 0;
  localparam int unsigned PIRQ_BIT_SERIAL_TWO = 7;
  localparam int unsigned PIRQ_BIT_BUS_COLL_TWO = 6;

  localparam int unsigned PIRQ_CTRL_W = 2;
  localparam int unsigned PIRQ_CTRL_PRIO_LEVELS = 0;
  localparam int unsigned PIRQ_CTRL_PERIPH_GLOBAL = 1;
  localparam logic [1:0] PIRQ_CTRL_RST = 2'h0;

  localparam int unsigned PIRQ_IRQ_W = 2;
  localparam int unsigned PIRQ_IRQ_HIGH = 0;
  localparam int unsigned PIRQ_IRQ_LOW = 1;
  localparam logic [1:0] PIRQ_IRQ_RST = 2'h0;

  localparam int unsigned PIRQ_CMP_W = 2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PIRQ_CCP_CAPTURE = 2'b00,
    PIRQ_CCP_COMPARE = 2'b01,
    PIRQ_CCP_PWM = 2'b10,
    PIRQ_CCP_OFF = 2'b11
  } pirq_ccp_mode_t;

  typedef struct packed {
    logic [7:0] one_evt;
    logic osc_fail;
    logic bus_coll_one;
    logic capcomp_two_capture;
    logic capcomp_two_compare;
    pirq_ccp_mode_t capcomp_two_mode;
    logic serial_two_done;
    logic bus_coll_two;
  } pirq_events_t;

  typedef struct packed {
    logic high;
    logic low;
  } pirq_core_req_t;

endpackage

/* pirq_flag_bank.sv */
// peripheral interrupt flags, enables and priority steering behind AXI4-Lite
// Function
// - oscillator-fail flag, second flag register bit 7, set on clock fallback, sticky
// - comparator-change flag, bit 6, set on comparator change, held till cleared
// - bit 3 of second flags set on first serial port bus collision
// - bit 0: capture in capture mode, match in compare mode, never in pwm
// - unimplemented bits read zero and ignore writes
// - third flags bit 7 set when second serial port finishes a transfer
// - third flags bit 6 set on second serial port bus collision
// - without priority levels, peripheral global enable gates every peripheral source
// - first enable register gates its eight sources, one means enabled
// - without parallel slave port its enable and priority bits read zero
// - second enable register gates bits 7, 6, 3 and 0
// - third enable register gates bits 7 and 6
// - priority bits steer only while priority levels are enabled
// - first priority register: one high, zero low, resets to all ones
// - flags stay set until software writes zero
// - flags set regardless of their enable or any global enable
// - priority levels enable selects two levels, else one compatible level
// - with priorities, low global enable gates all low-priority sources
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module pirq_flag_bank
  import pirq_pkg::*;
#(
  parameter bit PSP_PRESENT = 1'b1
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [pirq_pkg::PIRQ_ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [pirq_pkg::PIRQ_DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [pirq_pkg::PIRQ_ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // axi4-lite read data
  input wire logic rvalid_unused_guard,
  output logic rvalid,
  input wire logic rready,
  output logic [pirq_pkg::PIRQ_DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  // peripheral events, same clock
  input wire pirq_pkg::pirq_events_t events,
  // comparator outputs, asynchronous
  input wire logic [pirq_pkg::PIRQ_CMP_W-1:0] comparator_out,
  // requests toward the core
  output pirq_pkg::pirq_core_req_t core_req,
  // summary interrupt
  output logic irq
);
  import pirq_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [PIRQ_ADDR_W-1:0] a, input logic [7:0] off);
    hit = (a[PIRQ_ADDR_W-1:2] == off[PIRQ_ADDR_W-1:2]);
  endfunction

  function automatic logic [7:0] upd(input logic [7:0] cur, input logic we,
                                     input logic [7:0] wv, input logic [7:0] msk);
    upd = (we ? wv : cur) & msk;
  endfunction

  localparam logic [7:0] MASK_ONE = PSP_PRESENT ? PIRQ_MASK_ONE : PIRQ_MASK_NO_PSP;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] flags_one_q, flags_two_q, flags_three_q;
  logic [7:0] flags_one_d, flags_two_d, flags_three_d;
  logic [7:0] en_one_q, en_two_q, en_three_q, prio_one_q;
  logic [PIRQ_CTRL_W-1:0] ctrl_q;
  logic [PIRQ_IRQ_W-1:0] irq_status_q, irq_status_d, irq_mask_q;
  logic [PIRQ_CMP_W-1:0] cmp_meta_q, cmp_sync_q, cmp_prev_q;
  pirq_core_req_t req_prev_q;

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  logic aw_have_q, w_have_q, bvalid_q;
  logic [PIRQ_ADDR_W-1:0] awaddr_q;
  logic [7:0] wbyte_q;
  logic wlane_q;
  logic [1:0] bresp_q;

  wire aw_take = awvalid && awready;
  wire w_take = wvalid && wready;
  wire wr_fire = aw_have_q && w_have_q && !bvalid_q;
  wire wr_lane = wr_fire && wlane_q;
  wire wr_flags_one = wr_lane && hit(awaddr_q, PIRQ_OFF_FLAGS_ONE);
  wire wr_flags_two = wr_lane && hit(awaddr_q, PIRQ_OFF_FLAGS_TWO);
  wire wr_flags_three = wr_lane && hit(awaddr_q, PIRQ_OFF_FLAGS_THREE);
  wire wr_en_one = wr_lane && hit(awaddr_q, PIRQ_OFF_ENABLES_ONE);
  wire wr_en_two = wr_lane && hit(awaddr_q, PIRQ_OFF_ENABLES_TWO);
  wire wr_en_three = wr_lane && hit(awaddr_q, PIRQ_OFF_ENABLES_THREE);
  wire wr_prio_one = wr_lane && hit(awaddr_q, PIRQ_OFF_PRIORITY_ONE);
  wire wr_ctrl = wr_lane && hit(awaddr_q, PIRQ_OFF_CONTROL);
  wire wr_mask = wr_lane && hit(awaddr_q, PIRQ_OFF_IRQ_MASK);
  wire wr_mapped = hit(awaddr_q, PIRQ_OFF_FLAGS_ONE) || hit(awaddr_q, PIRQ_OFF_FLAGS_TWO)
    || hit(awaddr_q, PIRQ_OFF_FLAGS_THREE) || hit(awaddr_q, PIRQ_OFF_ENABLES_ONE)
    || hit(awaddr_q, PIRQ_OFF_ENABLES_TWO) || hit(awaddr_q, PIRQ_OFF_ENABLES_THREE)
    || hit(awaddr_q, PIRQ_OFF_PRIORITY_ONE) || hit(awaddr_q, PIRQ_OFF_CONTROL)
    || hit(awaddr_q, PIRQ_OFF_IRQ_STATUS) || hit(awaddr_q, PIRQ_OFF_IRQ_MASK);

  assign awready = !aw_have_q && !bvalid_q;
  assign wready = !w_have_q && !bvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      awaddr_q <= '0;
      wbyte_q <= PIRQ_RST_ZERO;
      wlane_q <= 1'b0;
      bresp_q <= PIRQ_RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        aw_have_q <= 1'b1;
        awaddr_q <= awaddr;
      end
      if (w_take)
      begin
        w_have_q <= 1'b1;
        wbyte_q <= wdata[7:0];
        wlane_q <= wstrb[0];
      end
      if (wr_fire)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_mapped ? PIRQ_RESP_OKAY : PIRQ_RESP_SLVERR;
      end
      else if (bvalid_q && bready)
        bvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  logic rvalid_q;
  logic [PIRQ_DATA_W-1:0] rdata_q;
  logic [1:0] rresp_q;

  wire ar_take = arvalid && arready;
  wire rd_status = ar_take && hit(araddr, PIRQ_OFF_IRQ_STATUS);
  wire [7:0] rd_byte =
    hit(araddr, PIRQ_OFF_FLAGS_ONE) ? flags_one_q :
    hit(araddr, PIRQ_OFF_FLAGS_TWO) ? flags_two_q :
    hit(araddr, PIRQ_OFF_FLAGS_THREE) ? flags_three_q :
    hit(araddr, PIRQ_OFF_ENABLES_ONE) ? en_one_q :
    hit(araddr, PIRQ_OFF_ENABLES_TWO) ? en_two_q :
    hit(araddr, PIRQ_OFF_ENABLES_THREE) ? en_three_q :
    hit(araddr, PIRQ_OFF_PRIORITY_ONE) ? prio_one_q :
    hit(araddr, PIRQ_OFF_CONTROL) ? {6'h00, ctrl_q} :
    hit(araddr, PIRQ_OFF_IRQ_STATUS) ? {6'h00, irq_status_q} :
    hit(araddr, PIRQ_OFF_IRQ_MASK) ? {6'h00, irq_mask_q} : PIRQ_RST_ZERO;
  wire rd_mapped = hit(araddr, PIRQ_OFF_FLAGS_ONE) || hit(araddr, PIRQ_OFF_FLAGS_TWO)
    || hit(araddr, PIRQ_OFF_FLAGS_THREE) || hit(araddr, PIRQ_OFF_ENABLES_ONE)
    || hit(araddr, PIRQ_OFF_ENABLES_TWO) || hit(araddr, PIRQ_OFF_ENABLES_THREE)
    || hit(araddr, PIRQ_OFF_PRIORITY_ONE) || hit(araddr, PIRQ_OFF_CONTROL)
    || hit(araddr, PIRQ_OFF_IRQ_STATUS) || hit(araddr, PIRQ_OFF_IRQ_MASK);

  assign arready = !rvalid_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= PIRQ_RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h000000, rd_byte};
      rresp_q <= rd_mapped ? PIRQ_RESP_OKAY : PIRQ_RESP_SLVERR;
    end
    else if (rvalid_q && rready)
      rvalid_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // event capture
  // ----------------------------------------------------------------
  // comparator levels come from the analog side: two stages first
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cmp_meta_q <= '0;
      cmp_sync_q <= '0;
      cmp_prev_q <= '0;
    end
    else
    begin
      cmp_meta_q <= comparator_out;
      cmp_sync_q <= cmp_meta_q;
      cmp_prev_q <= cmp_sync_q;
    end
  end

  wire cmp_change = |(cmp_sync_q ^ cmp_prev_q);
  wire ccp2_evt = (events.capcomp_two_mode == PIRQ_CCP_CAPTURE && events.capcomp_two_capture)
    || (events.capcomp_two_mode == PIRQ_CCP_COMPARE && events.capcomp_two_compare);

  wire [7:0] set_two = {events.osc_fail, cmp_change, 2'b00, events.bus_coll_one,
                        2'b00, ccp2_evt};
  wire [7:0] set_three = {events.serial_two_done, events.bus_coll_two, 6'h00};

  // set wins over a software clear in the same cycle; enables not consulted
  assign flags_one_d = upd(flags_one_q, wr_flags_one, wbyte_q, MASK_ONE)
    | (events.one_evt & MASK_ONE);
  assign flags_two_d = upd(flags_two_q, wr_flags_two, wbyte_q, PIRQ_MASK_TWO)
    | (set_two & PIRQ_MASK_TWO);
  assign flags_three_d = upd(flags_three_q, wr_flags_three, wbyte_q, PIRQ_MASK_THREE)
    | (set_three & PIRQ_MASK_THREE);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flags_one_q <= PIRQ_RST_ZERO;
      flags_two_q <= PIRQ_RST_ZERO;
      flags_three_q <= PIRQ_RST_ZERO;
    end
    else
    begin
      flags_one_q <= flags_one_d;
      flags_two_q <= flags_two_d;
      flags_three_q <= flags_three_d;
    end
  end

  // ----------------------------------------------------------------
  // enables, priorities, control
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      en_one_q <= PIRQ_RST_ZERO;
      en_two_q <= PIRQ_RST_ZERO;
      en_three_q <= PIRQ_RST_ZERO;
      prio_one_q <= PIRQ_RST_PRIORITY & MASK_ONE;
      ctrl_q <= PIRQ_CTRL_RST;
      irq_mask_q <= PIRQ_IRQ_RST;
    end
    else
    begin
      en_one_q <= upd(en_one_q, wr_en_one, wbyte_q, MASK_ONE);
      en_two_q <= upd(en_two_q, wr_en_two, wbyte_q, PIRQ_MASK_TWO);
      en_three_q <= upd(en_three_q, wr_en_three, wbyte_q, PIRQ_MASK_THREE);
      prio_one_q <= upd(prio_one_q, wr_prio_one, wbyte_q, MASK_ONE);
      if (wr_ctrl)
        ctrl_q <= wbyte_q[PIRQ_CTRL_W-1:0];
      if (wr_mask)
        irq_mask_q <= wbyte_q[PIRQ_IRQ_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // request steering
  // ----------------------------------------------------------------
  wire prio_levels = ctrl_q[PIRQ_CTRL_PRIO_LEVELS];
  wire periph_global = ctrl_q[PIRQ_CTRL_PERIPH_GLOBAL];
  wire [7:0] pend_one = flags_one_q & en_one_q;
  wire [7:0] pend_two = flags_two_q & en_two_q;
  wire [7:0] pend_three = flags_three_q & en_three_q;
  // second and third sources have no priority bits here: fixed high
  wire pend_hi = |(pend_one & prio_one_q) || |pend_two || |pend_three;
  wire pend_lo = |(pend_one & ~prio_one_q);
  wire pend_any = |pend_one || |pend_two || |pend_three;
  wire req_high_d = prio_levels ? pend_hi : (pend_any && periph_global);
  wire req_low_d = prio_levels && pend_lo && periph_global;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      core_req <= '0;
      req_prev_q <= '0;
    end
    else
    begin
      core_req.high <= req_high_d;
      core_req.low <= req_low_d;
      req_prev_q <= core_req;
    end
  end

  // ----------------------------------------------------------------
  // summary interrupt
  // ----------------------------------------------------------------
  wire [PIRQ_IRQ_W-1:0] irq_evt = {core_req.low && !req_prev_q.low,
                                   core_req.high && !req_prev_q.high};
  assign irq_status_d = (rd_status ? PIRQ_IRQ_RST : irq_status_q) | irq_evt;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_status_q <= PIRQ_IRQ_RST;
    else
      irq_status_q <= irq_status_d;
  end

  assign irq = |(irq_status_q & irq_mask_q);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_osc_fail_set: assert property (@(posedge aclk) disable iff (!aresetn)
    events.osc_fail |=> flags_two_q[PIRQ_BIT_OSC_FAIL])
    else $error("oscillator fail flag not set");

  a_bus_coll_two_set: assert property (@(posedge aclk) disable iff (!aresetn)
    events.bus_coll_two |=> flags_three_q[PIRQ_BIT_BUS_COLL_TWO])
    else $error("second bus collision flag not set");

  a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    (flags_three_q[PIRQ_BIT_SERIAL_TWO] && !wr_flags_three) |=>
      flags_three_q[PIRQ_BIT_SERIAL_TWO])
    else $error("serial done flag dropped without write");

  a_ccp_pwm_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    (events.capcomp_two_mode == PIRQ_CCP_PWM && !flags_two_q[PIRQ_BIT_CAPCOMP_TWO]
      && !wr_flags_two) |=> !flags_two_q[PIRQ_BIT_CAPCOMP_TWO])
    else $error("capture compare flag set in pwm mode");

  a_unimpl_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    ((flags_two_q & ~PIRQ_MASK_TWO) == PIRQ_RST_ZERO)
      && ((en_three_q & ~PIRQ_MASK_THREE) == PIRQ_RST_ZERO)
      && ((prio_one_q & ~MASK_ONE) == PIRQ_RST_ZERO))
    else $error("unimplemented bit reads one");

  a_periph_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    (!prio_levels && !periph_global) |=> !core_req.high && !core_req.low)
    else $error("request without peripheral global enable");

  a_low_steer: assert property (@(posedge aclk) disable iff (!aresetn)
    (prio_levels && periph_global && pend_lo) |=> core_req.low)
    else $error("low priority source not routed low");

  a_high_steer: assert property (@(posedge aclk) disable iff (!aresetn)
    (prio_levels && !periph_global && |(pend_one & prio_one_q)) |=>
      core_req.high && !core_req.low)
    else $error("high priority source misrouted");

  a_irq_raise: assert property (@(posedge aclk) disable iff (!aresetn)
    ($rose(core_req.high) && irq_mask_q[PIRQ_IRQ_HIGH] && !wr_mask) |=> irq)
    else $error("summary interrupt missed");

  a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (bvalid && !bready) |=> bvalid && $stable(bresp))
    else $error("write response dropped early");

endmodule

`default_nettype wire

/* pirq_periph_model.sv */
// peripheral event source standing in for the on-chip peripherals
`timescale 1ns/1ps
`default_nettype none

module pirq_periph_model
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // commands from the bench
  input wire logic fire_valid,
  input wire logic [3:0] fire_code,
  input wire pirq_pkg::pirq_ccp_mode_t ccp_mode,
  // toward the flag bank
  output pirq_pkg::pirq_events_t events,
  output logic [pirq_pkg::PIRQ_CMP_W-1:0] comparator_out
);
  import pirq_pkg::*;

  pirq_events_t evt_q;
  logic [PIRQ_CMP_W-1:0] cmp_q;

  // ----------------------------------------------------------------
  // one-cycle event pulses, comparator level toggles
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      evt_q <= '0;
      cmp_q <= '0;
    end
    else
    begin
      evt_q <= '0;
      evt_q.capcomp_two_mode <= ccp_mode;
      if (fire_valid)
      begin
        case (fire_code)
          4'h8: evt_q.osc_fail <= 1'b1;
          4'h9: evt_q.bus_coll_one <= 1'b1;
          4'hA: evt_q.capcomp_two_capture <= 1'b1;
          4'hB: evt_q.capcomp_two_compare <= 1'b1;
          4'hC: evt_q.serial_two_done <= 1'b1;
          4'hD: evt_q.bus_coll_two <= 1'b1;
          4'hE: cmp_q[0] <= ~cmp_q[0];
          default: evt_q.one_evt[fire_code[2:0]] <= 1'b1;
        endcase
      end
    end
  end

  assign events = evt_q;
  assign comparator_out = cmp_q;
endmodule

`default_nettype wire

/* pirq_flag_bank_tb.sv */
// self-checking bench for the peripheral interrupt flag bank
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end

module pirq_flag_bank_tb;
  import pirq_pkg::*;

  // ----------------------------------------------------------------
  // signals and tables
  // ----------------------------------------------------------------
  logic aclk = 1'b0;
  logic aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq, fire_valid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rdata_small, got_small;
  logic [1:0] bresp, rresp, cmp_out;
  logic [3:0] wstrb;
  logic [2:0] prot;
  logic [3:0] fire_code;
  pirq_ccp_mode_t ccp_mode;
  pirq_events_t events;
  pirq_core_req_t core_req;
  int n_errors = 0;
  int samples_checked = 0;
  localparam logic [7:0] WM [7] = '{8'hFF, 8'hC9, 8'hC0, 8'hFF, 8'hC9, 8'hC0, 8'hFF};
  localparam logic [3:0] EC [6] = '{4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD};
  localparam logic [7:0] EV [6] = '{8'h80, 8'h08, 8'h01, 8'h01, 8'h80, 8'h40};
  // routing steps: register offset, value, expected {high, low}
  localparam logic [7:0] RA [8] = '{8'h0C, 8'h1C, 8'h18, 8'h1C, 8'h1C, 8'h18, 8'h1C, 8'h0C};
  localparam logic [7:0] RD [8] = '{8'h01, 8'h02, 8'h00, 8'h01, 8'h03, 8'hFF, 8'h01, 8'h00};
  localparam logic [1:0] RQ [8] = '{2'b00, 2'b10, 2'b10, 2'b00, 2'b01, 2'b10, 2'b10, 2'b00};

  always #2 aclk = ~aclk;

  pirq_periph_model pm (.aclk(aclk), .aresetn(aresetn), .fire_valid(fire_valid),
    .fire_code(fire_code), .ccp_mode(ccp_mode), .events(events), .comparator_out(cmp_out));

  pirq_flag_bank uut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(prot), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .arprot(prot), .rvalid_unused_guard(1'b0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .events(events),
    .comparator_out(cmp_out), .core_req(core_req), .irq(irq));

  // small package variant, same bus traffic, only read data watched
  pirq_flag_bank #(.PSP_PRESENT(1'b0)) uut_small (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(), .awaddr(awaddr), .awprot(prot), .wvalid(wvalid),
    .wready(), .wdata(wdata), .wstrb(wstrb), .bvalid(), .bready(bready), .bresp(),
    .arvalid(arvalid), .arready(), .araddr(araddr), .arprot(prot),
    .rvalid_unused_guard(1'b0), .rvalid(), .rready(rready), .rdata(rdata_small),
    .rresp(), .events(events), .comparator_out(cmp_out), .core_req(), .irq());

  // ----------------------------------------------------------------
  // bus and event tasks
  // ----------------------------------------------------------------
  // response accepted one cycle late so that a held response is seen
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] e = PIRQ_RESP_OKAY, input logic [3:0] s = 4'hF);
    begin
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= {24'h0, d};
      wstrb <= s;
      bready <= 1'b0;
      do
      begin
        @(posedge aclk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        if (bvalid && !bready) bready <= 1'b1;
      end while (!(bvalid && bready));
      `CHK(bresp, e)
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input logic [1:0] r = PIRQ_RESP_OKAY);
    begin
      arvalid <= 1'b1;
      araddr <= a;
      do
      begin
        @(posedge aclk);
        if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      got_small = rdata_small;
      `CHK(rresp, r)
      `CHK(rdata, {24'h0, e})
    end
  endtask

  task automatic fire(input logic [3:0] c);
    begin
      fire_valid <= 1'b1;
      fire_code <= c;
      @(posedge aclk);
      fire_valid <= 1'b0;
      repeat (5) @(posedge aclk);
    end
  endtask

  task automatic settle;
    repeat (3) @(posedge aclk);
  endtask

  task automatic conclude;
    begin
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    conclude();
  end

  initial
  begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    fire_valid = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    prot = 3'h0;
    fire_code = 4'h0;
    ccp_mode = PIRQ_CCP_CAPTURE;
    bready = 1'b1;
    rready = 1'b1;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // reset values, one word per register
    for (int i = 0; i < 10; i++)
    begin
      rd(8'(i * 4), (i == 6) ? PIRQ_RST_PRIORITY : PIRQ_RST_ZERO);
      if (i == 6) `CHK(got_small[7:0], 8'h7F)
    end
    // writable and unimplemented bits
    for (int i = 0; i < 7; i++)
    begin
      wr(8'(i * 4), 8'hFF);
      rd(8'(i * 4), WM[i]);
      `CHK(got_small[7:0], (i % 3 == 0) ? 8'h7F : WM[i])
      wr(8'(i * 4), 8'h00);
      rd(8'(i * 4), 8'h00);
    end
    wr(PIRQ_OFF_PRIORITY_ONE, 8'hFF);
    // event flags with every enable off
    for (int i = 0; i < 6; i++)
    begin
      logic [7:0] fa;
      fa = (i < 4) ? PIRQ_OFF_FLAGS_TWO : PIRQ_OFF_FLAGS_THREE;
      ccp_mode <= (i == 3) ? PIRQ_CCP_COMPARE : PIRQ_CCP_CAPTURE;
      fire(EC[i]);
      rd(fa, EV[i]);
      rd(fa, EV[i]);
      wr(fa, 8'h00);
      rd(fa, 8'h00);
    end
    fire(4'hE);
    rd(PIRQ_OFF_FLAGS_TWO, 8'h40);
    wr(PIRQ_OFF_FLAGS_TWO, 8'h00);
    ccp_mode <= PIRQ_CCP_PWM;
    fire(4'hA);
    fire(4'hB);
    rd(PIRQ_OFF_FLAGS_TWO, 8'h00);
    rd(8'h40, 8'h00, PIRQ_RESP_SLVERR);
    wr(8'h40, 8'h5A, PIRQ_RESP_SLVERR);
    // routing of a first-register source
    fire(4'h0);
    for (int i = 0; i < 8; i++)
    begin
      wr(RA[i], RD[i]);
      settle();
      `CHK(core_req, RQ[i])
    end
    // summary interrupt: status, mask, read clear
    `CHK(irq, 1'b0)
    rd(PIRQ_OFF_IRQ_STATUS, 8'h03);
    rd(PIRQ_OFF_IRQ_STATUS, 8'h00);
    wr(PIRQ_OFF_IRQ_MASK, 8'h01);
    fire(4'h9);
    wr(PIRQ_OFF_ENABLES_TWO, 8'h08);
    settle();
    `CHK(core_req, 2'b10)
    `CHK(irq, 1'b1)
    rd(PIRQ_OFF_IRQ_STATUS, 8'h01);
    settle();
    `CHK(irq, 1'b0)
    wr(PIRQ_OFF_FLAGS_TWO, 8'h00);
    settle();
    `CHK(core_req, 2'b00)
    // low lane strobe off: write accepted, register untouched
    prot <= 3'h7;
    wr(PIRQ_OFF_ENABLES_ONE, 8'hFF, PIRQ_RESP_OKAY, 4'hE);
    rd(PIRQ_OFF_ENABLES_ONE, 8'h00);
    conclude();
  end
endmodule

`default_nettype wire
